//--- dv/ppqs_pad_model.sv
// Pad model: pin level from design drive, far-side drive and pulls
`timescale 1ns/10ps
module ppqs_pad_model #(
	parameter int N = 8
) (
	input  wire logic         clk,
	input  wire logic [N-1:0] padOe_n,
	input  wire logic [N-1:0] padOut,
	input  wire logic [N-1:0] pullOn,
	input  wire logic [N-1:0] pullDown,
	input  wire logic [N-1:0] farOn,
	input  wire logic [N-1:0] farVal,
	output logic      [N-1:0] level
);
	logic [N-1:0] floatFf = '0;
	// A floating pin toggles so a stale level never looks driven
	always_ff @(posedge clk) floatFf <= ~level;
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (!padOe_n[i]) level[i] = padOut[i];
			else if (farOn[i]) level[i] = farVal[i];
			else if (pullOn[i]) level[i] = ~pullDown[i];
			else level[i] = floatFf[i];
		end
	end
endmodule : ppqs_pad_model

//--- dv/ppqs_pin_control_chk.sv
// Assertion checker for the port pin control block
`timescale 1ns/10ps
module ppqs_pin_control_chk
	import ppqs_pkg::*;
#(
	parameter int MOTOR_N = 6,
	parameter int QN      = 7,
	parameter int SN      = 8
) (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic [MOTOR_N-1:0]    motorPinIsOutput,
	input wire logic [MOTOR_N-1:0]    motorReducedDrive,
	input wire logic [MOTOR_N-1:0]    motorPullEnable,
	input wire logic [MOTOR_N-1:0]    motorPullDown,
	input wire logic [QN-1:0]         portQPinIn,
	input wire logic [QN-1:0]         portQPinOe_n,
	input wire logic [QN-1:0]         portQPullEnable,
	input wire logic [QN-1:0]         motorInputFuncEn,
	input wire logic [PQ_FAULT_W-1:0] motorFaultIn,
	input wire logic [PQ_SENSE_W-1:0] currentSenseIn_n,
	input wire logic [SN-1:0]         portSPinIn,
	input wire logic [SN-1:0]         portSPinOe_n,
	input wire logic                  spiEnable,
	input wire logic [PS_SPI_W-1:0]   spiPinIn,
	input wire logic                  serialOneReceive,
	input wire logic                  serialZeroReceive
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_READY: assert property (psel && !penable ##1 psel && penable |-> pready)
		else $error("no ready in access cycle");
	AST_MDRV: assert property ((motorReducedDrive & ~motorPinIsOutput) == '0)
		else $error("reduced drive on input");
	AST_MPULL: assert property ((motorPullEnable & motorPinIsOutput) == '0)
		else $error("pull on output");
	AST_MPOL: assert property ((motorPullDown & ~motorPullEnable) == '0)
		else $error("polarity without pull");
	AST_QPULL: assert property ((portQPullEnable & ~portQPinOe_n) == '0)
		else $error("pull on driven pin");
	AST_QFORCE: assert property ((~portQPinOe_n & motorInputFuncEn) == '0)
		else $error("forced input driven");
	AST_QFEED: assert property ({currentSenseIn_n, motorFaultIn} == portQPinIn)
		else $error("fault or sense feed wrong");
	AST_SFEED: assert property ({spiPinIn, serialOneReceive, serialZeroReceive}
		== {portSPinIn[7:4], portSPinIn[2], portSPinIn[0]}) else $error("rx feed wrong");
	AST_RST: assert property ($rose(rst_n) |-> &portQPinOe_n && &portSPinOe_n)
		else $error("pin driven after reset");
	cover property (psel && penable);
	cover property (|motorInputFuncEn);
	cover property (spiEnable);
endmodule : ppqs_pin_control_chk

bind ppqs_pin_control ppqs_pin_control_chk #(.MOTOR_N(MOTOR_N), .QN(QN), .SN(SN)) i_chk (
	.clk, .rst_n, .psel, .penable, .pready, .motorPinIsOutput, .motorReducedDrive,
	.motorPullEnable, .motorPullDown, .portQPinIn, .portQPinOe_n, .portQPullEnable,
	.motorInputFuncEn, .motorFaultIn, .currentSenseIn_n, .portSPinIn, .portSPinOe_n,
	.spiEnable, .spiPinIn, .serialOneReceive, .serialZeroReceive);

//--- dv/ppqs_pin_control_test.sv
// Self-checking testbench for the port pin control block
`timescale 1ns/10ps
module ppqs_pin_control_test;
	import ppqs_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, sIn, sOut, sOe_n, sXe, sXv;
	logic [31:0] pwdata, prdata;
	logic [5:0] mOut, mDrv, mPe, mPd;
	logic [6:0] qIn, qOut, qOe_n, qDrv, qPe, qPd, qFn, qXe, qXv;
	logic [3:0] fault, spO, spD, spI;
	logic [2:0] sense_n;
	logic spiEn, s1t, s1r, s1x, s1i, s0t, s0r, s0x, s0i;
	int err_total = 0;
	int total_checks = 0;

	ppqs_pin_control i_ppqs_pin_control (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .motorPinIsOutput(mOut), .motorReducedDrive(mDrv),
		.motorPullEnable(mPe), .motorPullDown(mPd), .portQPinIn(qIn), .portQPinOut(qOut),
		.portQPinOe_n(qOe_n), .portQReducedDrive(qDrv), .portQPullEnable(qPe),
		.portQPullDown(qPd), .motorInputFuncEn(qFn), .motorFaultIn(fault),
		.currentSenseIn_n(sense_n), .portSPinIn(sIn), .portSPinOut(sOut), .portSPinOe_n(sOe_n),
		.spiEnable(spiEn), .spiPinOut(spO), .spiPinDrive(spD), .spiPinIn(spI),
		.serialOneTxEn(s1t), .serialOneRxEn(s1r), .serialOneTransmit(s1x),
		.serialOneReceive(s1i), .serialZeroTxEn(s0t), .serialZeroRxEn(s0r),
		.serialZeroTransmit(s0x), .serialZeroReceive(s0i));
	ppqs_pad_model #(.N(7)) padQ (.clk(clk), .padOe_n(qOe_n), .padOut(qOut),
		.pullOn(qPe), .pullDown(qPd), .farOn(qXe), .farVal(qXv), .level(qIn));
	ppqs_pad_model #(.N(8)) padS (.clk(clk), .padOe_n(sOe_n), .padOut(sOut),
		.pullOn(8'h00), .pullDown(8'h00), .farOn(sXe), .farVal(sXv), .level(sIn));

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; read data is compared only on reads
	task automatic apb(input logic [5:0] ix, input logic w, input logic [7:0] d,
		input logic [7:0] exp, input logic ex);
		int n;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ix, 2'b00, 24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_total++;
			give_verdict();
		end
		if (!w) chk(prdata, {24'h0, exp});
		chk(pslverr, ex);
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic t_reset;
		chk({qOe_n, sOe_n}, {7'h7f, 8'hff});
		chk({qPe, mPe, mDrv}, 19'h0);
		apb(IDX_PORTQ_DIRECTION, 0, 8'h00, 8'h00, 0);
	endtask : t_reset

	task automatic t_regs;
		logic [5:0] ix [8] = '{6'h1b, 6'h1c, 6'h1d, 6'h22, 6'h23, 6'h24, 6'h25, 6'h0a};
		logic [7:0] mk [8] = '{8'h3f, 8'h3f, 8'h3f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hff};
		for (int i = 0; i < 8; i++) begin
			apb(ix[i], 1, 8'hff, 8'h00, 0);
			apb(ix[i], 0, 8'h00, mk[i], 0);
			apb(ix[i], 1, 8'h00, 8'h00, 0);
		end
		apb(6'h3f, 1, 8'hff, 8'h00, 1);
		apb(6'h3f, 0, 8'h00, 8'h00, 1);
	endtask : t_regs

	task automatic t_qdata;
		{qXv, qXe, qFn} <= {7'h55, 7'h71, 7'h01};
		apb(IDX_PORTQ_DIRECTION, 1, 8'h0f, 8'h00, 0);
		apb(IDX_PORTQ_IO_DATA, 1, 8'h0a, 8'h00, 0);
		apb(IDX_PORTQ_PIN_LEVEL, 1, 8'hff, 8'h00, 0);
		apb(IDX_PORTQ_IO_DATA, 0, 8'h00, 8'h5a, 0);
		apb(IDX_PORTQ_PIN_LEVEL, 0, 8'h00, 8'h5b, 0);
		chk({qOe_n, fault, sense_n}, {7'h71, 4'hb, 3'h5});
		{qFn, qXe} <= {7'h00, 7'h70};
		@(posedge clk);
		chk(qOe_n, 7'h70);
		apb(IDX_PORTQ_PIN_LEVEL, 0, 8'h00, 8'h5a, 0);
	endtask : t_qdata

	task automatic t_pull;
		{qXe, mOut} <= {7'h00, 6'h07};
		apb(IDX_PORTQ_PULL_ENABLE, 1, 8'h7f, 8'h00, 0);
		apb(IDX_PORTQ_PULL_POLARITY, 1, 8'h55, 8'h00, 0);
		apb(IDX_PORTQ_DRIVE_STRENGTH, 1, 8'h33, 8'h00, 0);
		@(posedge clk);
		chk({qPe, qPd, qDrv}, {7'h70, 7'h50, 7'h03});
		apb(IDX_PORTQ_PIN_LEVEL, 0, 8'h00, 8'h2a, 0);
		apb(IDX_MOTOR_DRIVE_STRENGTH, 1, 8'hff, 8'h00, 0);
		apb(IDX_MOTOR_PULL_ENABLE, 1, 8'hff, 8'h00, 0);
		apb(IDX_MOTOR_PULL_POLARITY, 1, 8'h2a, 8'h00, 0);
		@(posedge clk);
		chk({mDrv, mPe, mPd}, {6'h07, 6'h38, 6'h28});
	endtask : t_pull

	task automatic t_ports;
		apb(IDX_PORTS_DIRECTION, 1, 8'hff, 8'h00, 0);
		apb(IDX_PORTS_IO_DATA, 1, 8'ha5, 8'h00, 0);
		apb(IDX_PORTS_IO_DATA, 0, 8'h00, 8'ha5, 0);
		chk({sOe_n, sOut}, 16'h00a5);
		{spiEn, spD, spO, s1t, s1r, s1x, s0t, s0r, s0x} <= {9'h153, 6'b110111};
		{sXe, sXv} <= {8'ha5, 8'h84};
		@(posedge clk);
		chk({sOe_n, sOut & ~sOe_n}, 16'ha512);
		chk({spI, s1i, s0i}, 6'h26);
		{spiEn, s1t, s1r, s0t, s0r, sXe} <= '0;
		@(posedge clk);
		chk(sOe_n, 8'h00);
	endtask : t_ports

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, mOut, qFn, qXe, qXv} = '0;
		{sXe, sXv, spiEn, spO, spD, s1t, s1r, s1x, s0t, s0r, s0x} = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_qdata();
		t_pull();
		t_ports();
		{spiEn, spD} <= {1'b1, 4'hf};
		rst_n <= 1'b0;
		@(posedge clk);
		chk(sOe_n, 8'hff);
		{spiEn, spD} <= '0;
		rst_n <= 1'b1;
		t_reset();
		give_verdict();
	end
endmodule : ppqs_pin_control_test

//--- rtl/ppqs_pin_control.sv
// Pin control for motor port drive/pull, port Q and port S with APB registers
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
// Functional notes
// - Drive-strength bit 1 gives reduced drive, 0 full; ignored on inputs.
// - Motor port drive-strength register holds six bits, 5 down to 0.
// - Pull-enable bit switches pull device on inputs only; no effect on outputs.
// - Pull polarity acts only when pin is input and pull enabled.
// - Polarity 0 selects pull-up, 1 selects pull-down, motor port and port Q.
// - Port Q gives motor PWM priority; enabled sense or fault makes pin input.
// - Port Q pins 3:0 feed fault inputs, pins 6:4 active-low current sense.
// - Port Q pins are high-impedance inputs during reset.
// - Data register read returns stored bit where direction bit is 1, pin level where it is 0.
// - Port Q pin-level register reads live pins; writes change nothing.
// - Port Q direction register bits 6:0; 0 input, 1 output.
// - Enabled motor PWM input forces input; direction bit rules again when off.
// - Port S gives SPI priority; pins 7:4 carry SS, SCK, MOSI, MISO.
// - Serial one uses pins 3:2, serial zero pins 1:0, transmit then receive.
// - Port S pins are high-impedance inputs during reset.
// - All read/write registers accept access at any time.
module ppqs_pin_control
	import ppqs_pkg::*;
#(
	parameter int MOTOR_N = MOTOR_PINS,
	parameter int QN      = PORTQ_PINS,
	parameter int SN      = PORTS_PINS
) (
	input  wire logic              clk,
	input  wire logic              rst_n,

	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,

	// Motor port pad controls
	input  wire logic [MOTOR_N-1:0] motorPinIsOutput,
	output logic      [MOTOR_N-1:0] motorReducedDrive,
	output logic      [MOTOR_N-1:0] motorPullEnable,
	output logic      [MOTOR_N-1:0] motorPullDown,

	// Port Q pads
	input  wire logic [QN-1:0]      portQPinIn,
	output logic      [QN-1:0]      portQPinOut,
	output logic      [QN-1:0]      portQPinOe_n,
	output logic      [QN-1:0]      portQReducedDrive,
	output logic      [QN-1:0]      portQPullEnable,
	output logic      [QN-1:0]      portQPullDown,

	// Motor PWM module side of port Q
	input  wire logic [QN-1:0]      motorInputFuncEn,
	output logic      [PQ_FAULT_W-1:0] motorFaultIn,
	output logic      [PQ_SENSE_W-1:0] currentSenseIn_n,

	// Port S pads
	input  wire logic [SN-1:0]      portSPinIn,
	output logic      [SN-1:0]      portSPinOut,
	output logic      [SN-1:0]      portSPinOe_n,

	// SPI side of port S (index 3 SS, 2 SCK, 1 MOSI, 0 MISO)
	input  wire logic              spiEnable,
	input  wire logic [PS_SPI_W-1:0] spiPinOut,
	input  wire logic [PS_SPI_W-1:0] spiPinDrive,
	output logic      [PS_SPI_W-1:0] spiPinIn,

	// Serial interfaces on port S
	input  wire logic              serialOneTxEn,
	input  wire logic              serialOneRxEn,
	input  wire logic              serialOneTransmit,
	output logic                   serialOneReceive,
	input  wire logic              serialZeroTxEn,
	input  wire logic              serialZeroRxEn,
	input  wire logic              serialZeroTransmit,
	output logic                   serialZeroReceive
);

	// Software-visible registers
	logic [MOTOR_N-1:0] motorDrive_ff;
	logic [MOTOR_N-1:0] motorPullEn_ff;
	logic [MOTOR_N-1:0] motorPullPol_ff;
	logic [QN-1:0]      qData_ff;
	logic [QN-1:0]      qDir_ff;
	logic [QN-1:0]      qDrive_ff;
	logic [QN-1:0]      qPullEn_ff;
	logic [QN-1:0]      qPullPol_ff;
	logic [SN-1:0]      sData_ff;
	logic [SN-1:0]      sDir_ff;
	logic [DATA_W-1:0]  prdata_ff;
	logic               pslverr_ff;
	logic               pinsLive_ff;

	// Bus decode
	logic [IDX_W-1:0]   regIdx;
	logic               aligned;
	logic               setupPhase;
	logic               wrStrobe;
	logic [REG_W-1:0]   wrByte;
	logic [REG_W-1:0]   nxt_rdByte;
	logic               nxt_err;

	// Pad steering
	logic [QN-1:0]      qEffOut;
	logic [SN-1:0]      sOwned;
	logic [SN-1:0]      sFnOut;
	logic [SN-1:0]      sFnDrive;
	logic [SN-1:0]      sEffOut;

	// APB decode; zero wait states so the access phase always completes
	assign regIdx     = paddr[IDX_LSB +: IDX_W];
	assign aligned    = (paddr[IDX_LSB-1:0] == 2'h0);
	assign setupPhase = psel & ~penable;
	assign wrStrobe   = psel & penable & pwrite & aligned;
	// Upper write data bits have no register behind them and are dropped
	assign wrByte     = pwdata[REG_W-1:0];
	assign pready     = psel & penable;
	assign prdata     = prdata_ff;
	assign pslverr    = pslverr_ff & pready;

	// Read data and error captured in the setup cycle, shown in the access cycle
	always_comb begin
		nxt_rdByte = 8'h00;
		nxt_err    = 1'b0;
		// Pin levels are sampled at the setup edge, so read data is one cycle old
		case (regIdx)
			IDX_PORTS_IO_DATA:        nxt_rdByte = (sDir_ff & sData_ff) | (~sDir_ff & portSPinIn);
			IDX_PORTS_DIRECTION:      nxt_rdByte = sDir_ff;
			IDX_MOTOR_DRIVE_STRENGTH: nxt_rdByte = REG_W'(motorDrive_ff);
			IDX_MOTOR_PULL_ENABLE:    nxt_rdByte = REG_W'(motorPullEn_ff);
			IDX_MOTOR_PULL_POLARITY:  nxt_rdByte = REG_W'(motorPullPol_ff);
			IDX_PORTQ_IO_DATA:        nxt_rdByte = REG_W'((qDir_ff & qData_ff) | (~qDir_ff & portQPinIn));
			IDX_PORTQ_PIN_LEVEL:      nxt_rdByte = REG_W'(portQPinIn);
			IDX_PORTQ_DIRECTION:      nxt_rdByte = REG_W'(qDir_ff);
			IDX_PORTQ_DRIVE_STRENGTH: nxt_rdByte = REG_W'(qDrive_ff);
			IDX_PORTQ_PULL_ENABLE:    nxt_rdByte = REG_W'(qPullEn_ff);
			IDX_PORTQ_PULL_POLARITY:  nxt_rdByte = REG_W'(qPullPol_ff);
			// Unmapped indices answer with an error and zero data
			default:                  nxt_err    = 1'b1;
		endcase
		// A misaligned address never aliases a register, whatever its index
		if (!aligned) begin
			nxt_rdByte = 8'h00;
			nxt_err    = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setupPhase) begin
			// Writes return zero so a stale read value never leaks onto the bus
			prdata_ff <= pwrite ? 32'h0000_0000 : {{(DATA_W-REG_W){1'b0}}, nxt_rdByte};
		end
	end

	// Error flag is decided in the setup cycle, like the read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pslverr_ff <= 1'b0;
		end else if (setupPhase) begin
			pslverr_ff <= nxt_err;
		end
	end

	// Motor port drive strength, six bits only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			motorDrive_ff <= RST_MOTOR;
		end else if (wrStrobe && regIdx == IDX_MOTOR_DRIVE_STRENGTH) begin
			motorDrive_ff <= wrByte[MOTOR_N-1:0];
		end
	end

	// Motor port pull enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			motorPullEn_ff <= RST_MOTOR;
		end else if (wrStrobe && regIdx == IDX_MOTOR_PULL_ENABLE) begin
			motorPullEn_ff <= wrByte[MOTOR_N-1:0];
		end
	end

	// Motor port pull polarity
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			motorPullPol_ff <= RST_MOTOR;
		end else if (wrStrobe && regIdx == IDX_MOTOR_PULL_POLARITY) begin
			motorPullPol_ff <= wrByte[MOTOR_N-1:0];
		end
	end

	// Port Q data; stored even while the pin is an input
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qData_ff <= RST_PORTQ;
		end else if (wrStrobe && regIdx == IDX_PORTQ_IO_DATA) begin
			qData_ff <= wrByte[QN-1:0];
		end
	end

	// Port Q direction; reset leaves every pin an input
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qDir_ff <= RST_PORTQ;
		end else if (wrStrobe && regIdx == IDX_PORTQ_DIRECTION) begin
			qDir_ff <= wrByte[QN-1:0];
		end
	end

	// Port Q drive strength
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qDrive_ff <= RST_PORTQ;
		end else if (wrStrobe && regIdx == IDX_PORTQ_DRIVE_STRENGTH) begin
			qDrive_ff <= wrByte[QN-1:0];
		end
	end

	// Port Q pull enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qPullEn_ff <= RST_PORTQ;
		end else if (wrStrobe && regIdx == IDX_PORTQ_PULL_ENABLE) begin
			qPullEn_ff <= wrByte[QN-1:0];
		end
	end

	// Port Q pull polarity
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qPullPol_ff <= RST_PORTQ;
		end else if (wrStrobe && regIdx == IDX_PORTQ_PULL_POLARITY) begin
			qPullPol_ff <= wrByte[QN-1:0];
		end
	end

	// Port S data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sData_ff <= RST_PORTS;
		end else if (wrStrobe && regIdx == IDX_PORTS_IO_DATA) begin
			sData_ff <= wrByte[SN-1:0];
		end
	end

	// Port S direction; reset leaves every pin an input
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sDir_ff <= RST_PORTS;
		end else if (wrStrobe && regIdx == IDX_PORTS_DIRECTION) begin
			sDir_ff <= wrByte[SN-1:0];
		end
	end

	// Port S pins stay undriven while reset is low, even if a peripheral asks to drive;
	// this costs one undriven cycle after release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinsLive_ff <= 1'b0;
		end else begin
			pinsLive_ff <= 1'b1;
		end
	end

	// Motor port pads; direction comes from the port P logic outside this block
	generate
		for (genvar mi = 0; mi < MOTOR_N; mi++) begin : g_pm
			assign motorReducedDrive[mi] = motorDrive_ff[mi] & motorPinIsOutput[mi];
			assign motorPullEnable[mi]   = motorPullEn_ff[mi] & ~motorPinIsOutput[mi];
			assign motorPullDown[mi]     = motorPullPol_ff[mi] & motorPullEnable[mi];
		end
	endgenerate

	// Port Q: an enabled motor PWM input overrides the direction bit
	// The data register keeps its value while a pin is forced to input
	generate
		for (genvar qi = 0; qi < QN; qi++) begin : g_pq
			assign qEffOut[qi]           = qDir_ff[qi] & ~motorInputFuncEn[qi];
			assign portQPinOut[qi]       = qData_ff[qi];
			assign portQPinOe_n[qi]      = ~qEffOut[qi];
			assign portQReducedDrive[qi] = qDrive_ff[qi] & qEffOut[qi];
			assign portQPullEnable[qi]   = qPullEn_ff[qi] & ~qEffOut[qi];
			assign portQPullDown[qi]     = qPullPol_ff[qi] & portQPullEnable[qi];
		end
	endgenerate

	// Pin levels reach the motor PWM module whatever the pin's GPIO role
	assign motorFaultIn      = portQPinIn[PQ_FAULT_W-1:0];
	assign currentSenseIn_n  = portQPinIn[PQ_SENSE_LSB +: PQ_SENSE_W];

	// Port S function ownership; receive pins are owned but never driven
	always_comb begin
		sOwned   = 8'h00;
		sFnOut   = 8'h00;
		sFnDrive = 8'h00;
		if (spiEnable) begin
			sOwned[PS_SPI_LSB +: PS_SPI_W]   = 4'hf;
			sFnOut[PS_SPI_LSB +: PS_SPI_W]   = spiPinOut;
			sFnDrive[PS_SPI_LSB +: PS_SPI_W] = spiPinDrive;
		end

		if (serialOneTxEn) begin
			sOwned[PS_S1_TX]   = 1'b1;
			sFnOut[PS_S1_TX]   = serialOneTransmit;
			sFnDrive[PS_S1_TX] = 1'b1;
		end

		// Receive pins are claimed so GPIO can never drive against the far end
		if (serialOneRxEn) begin
			sOwned[PS_S1_RX] = 1'b1;
		end

		if (serialZeroTxEn) begin
			sOwned[PS_S0_TX]   = 1'b1;
			sFnOut[PS_S0_TX]   = serialZeroTransmit;
			sFnDrive[PS_S0_TX] = 1'b1;
		end

		if (serialZeroRxEn) begin
			sOwned[PS_S0_RX] = 1'b1;
		end
	end

	// Per-pin mux between peripheral and GPIO
	// Ownership wins per pin; the direction bit rules again once the function is off
	genvar gi;
	generate
		for (gi = 0; gi < SN; gi++) begin : g_ps
			assign sEffOut[gi]      = sOwned[gi] ? sFnDrive[gi] : sDir_ff[gi];
			assign portSPinOut[gi]  = sOwned[gi] ? sFnOut[gi] : sData_ff[gi];
			assign portSPinOe_n[gi] = ~(sEffOut[gi] & pinsLive_ff);
		end
	endgenerate

	// Peripheral inputs see the pads directly; the peripheral gates by its own enable
	assign spiPinIn          = portSPinIn[PS_SPI_LSB +: PS_SPI_W];
	assign serialOneReceive  = portSPinIn[PS_S1_RX];
	assign serialZeroReceive = portSPinIn[PS_S0_RX];

endmodule : ppqs_pin_control

//--- rtl/ppqs_pkg.sv
// Constants shared by the port P/Q/S pin control block
package ppqs_pkg;

	// Pin counts per port
	localparam int MOTOR_PINS = 6;
	localparam int PORTQ_PINS = 7;
	localparam int PORTS_PINS = 8;

	// APB geometry
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 32;
	localparam int IDX_W       = 6;
	localparam int IDX_LSB     = 2;
	localparam int REG_W       = 8;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PORTS_IO_DATA        = 6'h08;
	localparam logic [IDX_W-1:0] IDX_PORTS_DIRECTION      = 6'h0a;
	localparam logic [IDX_W-1:0] IDX_MOTOR_DRIVE_STRENGTH = 6'h1b;
	localparam logic [IDX_W-1:0] IDX_MOTOR_PULL_ENABLE    = 6'h1c;
	localparam logic [IDX_W-1:0] IDX_MOTOR_PULL_POLARITY  = 6'h1d;
	localparam logic [IDX_W-1:0] IDX_PORTQ_IO_DATA        = 6'h20;
	localparam logic [IDX_W-1:0] IDX_PORTQ_PIN_LEVEL      = 6'h21;
	localparam logic [IDX_W-1:0] IDX_PORTQ_DIRECTION      = 6'h22;
	localparam logic [IDX_W-1:0] IDX_PORTQ_DRIVE_STRENGTH = 6'h23;
	localparam logic [IDX_W-1:0] IDX_PORTQ_PULL_ENABLE    = 6'h24;
	localparam logic [IDX_W-1:0] IDX_PORTQ_PULL_POLARITY  = 6'h25;

	// Reset values
	localparam logic [MOTOR_PINS-1:0] RST_MOTOR = 6'h00;
	localparam logic [PORTQ_PINS-1:0] RST_PORTQ = 7'h00;
	localparam logic [PORTS_PINS-1:0] RST_PORTS = 8'h00;

	// Port S pin positions of the shared functions
	localparam int PS_SPI_LSB = 4;
	localparam int PS_SPI_W   = 4;
	localparam int PS_S1_TX   = 3;
	localparam int PS_S1_RX   = 2;
	localparam int PS_S0_TX   = 1;
	localparam int PS_S0_RX   = 0;

	// Port Q pin positions of the motor PWM inputs
	localparam int PQ_FAULT_W = 4;
	localparam int PQ_SENSE_LSB = 4;
	localparam int PQ_SENSE_W = 3;

endpackage : ppqs_pkg
